// ===== hdl/pcat_pkg.sv
// constants and types shared by the configuration access translator
`default_nettype none
package pcat_pkg;
  // ****************************************************************
  // host i/o map
  // ****************************************************************
  localparam logic [15:0] PCAT_PTR_OFS   = 16'h0cf8;
  localparam logic [15:0] PCAT_WIN_OFS   = 16'h0cfc;
  localparam logic [31:0] PCAT_PTR_RST   = 32'h0000_0000;
  localparam logic [31:0] PCAT_WIN_RST   = 32'h0000_0000;
  localparam logic [31:0] PCAT_PTR_MASK  = 32'h80ff_ffff; // 30:24 read 0
  localparam logic [3:0]  PCAT_BE_FULL   = 4'hf;
  // ****************************************************************
  // pointer fields
  // ****************************************************************
  localparam int          PCAT_EN_BIT    = 31;
  localparam int          PCAT_BUS_LO    = 16;
  localparam int          PCAT_DEV_LO    = 11;
  localparam logic [7:0]  PCAT_OWN_BUS   = 8'h00;
  localparam logic [4:0]  PCAT_DEV_MIN   = 5'h01;
  localparam logic [4:0]  PCAT_DEV_MAX   = 5'h15;
  localparam logic [5:0]  PCAT_IDSEL_OFS = 6'h0a; // device 1 -> line 11
  localparam logic [1:0]  PCAT_TT_TYPE0  = 2'b00;
  localparam logic [1:0]  PCAT_TT_TYPE1  = 2'b01;
  localparam logic [31:0] PCAT_SPC_PTR   = 32'h8000_ff00;
  localparam logic [15:0] PCAT_MSG_SHUT  = 16'h0000;
  localparam logic [15:0] PCAT_MSG_HALT  = 16'h0001;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    PCAT_CMD_SPECIAL = 4'h1,
    PCAT_CMD_IO_RD   = 4'h2,
    PCAT_CMD_IO_WR   = 4'h3,
    PCAT_CMD_CFG_RD  = 4'ha,
    PCAT_CMD_CFG_WR  = 4'hb
  } pcat_cmd_t;
  typedef enum {PCAT_IDLE, PCAT_BUS} pcat_state_t;
endpackage : pcat_pkg
`default_nettype wire

// ===== hdl/pcat_translator.sv
// configuration mechanism translator between host i/o and pci cycles
// Contract
// - pointer decoded at cf8h, data window at cfch, four bytes each
// - only full 32-bit writes load pointer; narrower ones go out as i/o
// - pointer bit 31 enables translation; clear means plain i/o cycles
// - enabled window access makes config cycle from pointer fields
// - window takes 8, 16, 32-bit accesses, byte lanes carried through
// - pointer fields bus, device, function, register; 30:24 zero
// - local devices 01h..15h map one-hot onto lines 11 up to 31
// - own bus number 00h picks type 0, otherwise type 1
// - type 0 passes bits 10:2, drives device select, low bits 00
// - type 1 copies pointer onto address, low bits 01
// - every window write while the special pointer is held is a special cycle
// - halt and shutdown requests issue fixed special-cycle messages
`default_nettype none
module pcat_translator
  import pcat_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                io_req,
  input  wire logic                io_we,
  input  wire logic [15:0]         io_addr,
  input  wire logic [3:0]          io_be,
  input  wire logic [31:0]         io_wdata,
  output var  logic                io_ack,
  output var  logic [31:0]         io_rdata,
  input  wire logic                halt_req,
  input  wire logic                shutdown_req,
  output var  logic                pci_req,
  output var  pcat_pkg::pcat_cmd_t pci_cmd,
  output var  logic [31:0]         pci_addr,
  output var  logic [3:0]          pci_be,
  output var  logic [31:0]         pci_wdata,
  input  wire logic                pci_done,
  input  wire logic [31:0]         pci_rdata
);
  // ****************************************************************
  // state
  // ****************************************************************
  pcat_state_t state, next_state;
  logic [31:0] ptr, next_ptr;
  logic [31:0] window, next_window;
  logic        pend_halt, next_pend_halt;
  logic        pend_shut, next_pend_shut;
  logic        from_host, next_from_host;
  logic        to_window, next_to_window;
  logic        next_io_ack, next_pci_req;
  logic [31:0] next_io_rdata, next_pci_addr, next_pci_wdata;
  logic [3:0]  next_pci_be;
  pcat_cmd_t   next_pci_cmd;

  // ****************************************************************
  // address decode and config address build
  // ****************************************************************
  logic        hit_ptr, hit_win, full, xlate, special, own_bus;
  logic [4:0]  dev;
  logic [31:0] idsel, cfg_addr;

  // decode of the two host words and the pointer's target
  assign hit_ptr = io_addr[15:2] == PCAT_PTR_OFS[15:2];
  assign hit_win = io_addr[15:2] == PCAT_WIN_OFS[15:2];
  assign full    = io_be == PCAT_BE_FULL;
  assign xlate   = hit_win && ptr[PCAT_EN_BIT];
  assign special = ptr[31:2] == PCAT_SPC_PTR[31:2];
  assign own_bus = ptr[PCAT_BUS_LO +: 8] == PCAT_OWN_BUS;
  assign dev     = ptr[PCAT_DEV_LO +: 5];

  // one-hot device select; devices outside the range select nobody
  always_comb
  begin
    idsel = 32'h0;
    if (dev >= PCAT_DEV_MIN && dev <= PCAT_DEV_MAX)
      idsel = 32'h1 << ({1'b0, dev} + PCAT_IDSEL_OFS);
    if (own_bus)
      cfg_addr = idsel | {21'h0, ptr[10:2], PCAT_TT_TYPE0};
    else
      cfg_addr = {ptr[31:2], PCAT_TT_TYPE1};
  end

  // ****************************************************************
  // request sequencer
  // ****************************************************************
  // next values of the sequencer, pointer, window and bus outputs
  always_comb
  begin
    next_state     = state;
    next_ptr       = ptr;
    next_window    = window;
    next_pend_halt = pend_halt | halt_req;     // set wins, no clear here
    next_pend_shut = pend_shut | shutdown_req;
    next_from_host = from_host;
    next_to_window = to_window;
    next_io_ack    = 1'b0;
    next_io_rdata  = io_rdata;
    next_pci_req   = 1'b0;
    next_pci_cmd   = pci_cmd;
    next_pci_addr  = pci_addr;
    next_pci_be    = pci_be;
    next_pci_wdata = pci_wdata;
    unique case (state)
      PCAT_IDLE:
      begin
        if (io_req && hit_ptr && full)
        begin
          next_io_ack = 1'b1;
          if (io_we)
            next_ptr = io_wdata & PCAT_PTR_MASK;
          else
            next_io_rdata = ptr;
        end
        else if (io_req)
        begin
          next_state     = PCAT_BUS;
          next_from_host = 1'b1;
          next_to_window = xlate;
          next_pci_req   = 1'b1;
          next_pci_be    = io_be;
          next_pci_wdata = io_wdata;
          if (xlate && special && io_we)
          begin
            next_pci_cmd  = PCAT_CMD_SPECIAL;
            next_pci_addr = 32'h0;
          end
          else if (xlate)
          begin
            next_pci_cmd  = io_we ? PCAT_CMD_CFG_WR : PCAT_CMD_CFG_RD;
            next_pci_addr = cfg_addr;
          end
          else
          begin
            next_pci_cmd  = io_we ? PCAT_CMD_IO_WR : PCAT_CMD_IO_RD;
            next_pci_addr = {16'h0, io_addr};
          end
        end
        else if (pend_halt || pend_shut)
        begin
          next_state     = PCAT_BUS;
          next_from_host = 1'b0;
          next_to_window = 1'b0;
          next_pci_req   = 1'b1;
          next_pci_cmd   = PCAT_CMD_SPECIAL;
          next_pci_addr  = 32'h0;
          next_pci_be    = PCAT_BE_FULL;
          next_pci_wdata = {16'h0, pend_halt ? PCAT_MSG_HALT : PCAT_MSG_SHUT};
          if (pend_halt)
            next_pend_halt = halt_req;
          else
            next_pend_shut = shutdown_req;
        end
      end
      PCAT_BUS:
      begin
        if (pci_done)
        begin
          next_state    = PCAT_IDLE;
          next_io_ack   = from_host;
          next_io_rdata = pci_rdata;
          // window keeps the lanes moved by the last config or special window access
          if (to_window)
          begin
            for (int i = 0; i < 4; i++)
            begin
              if (pci_be[i])
                next_window[8*i +: 8] = pci_cmd == PCAT_CMD_IO_RD ||
                  pci_cmd == PCAT_CMD_CFG_RD ? pci_rdata[8*i +: 8]
                                             : pci_wdata[8*i +: 8];
            end
          end
        end
      end
    endcase
  end

  // registers of the sequencer and all outputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state     <= PCAT_IDLE;
      ptr       <= PCAT_PTR_RST;
      window    <= PCAT_WIN_RST;
      pend_halt <= 1'b0;
      pend_shut <= 1'b0;
      from_host <= 1'b0;
      to_window <= 1'b0;
      io_ack    <= 1'b0;
      io_rdata  <= 32'h0;
      pci_req   <= 1'b0;
      pci_cmd   <= PCAT_CMD_IO_RD;
      pci_addr  <= 32'h0;
      pci_be    <= 4'h0;
      pci_wdata <= 32'h0;
    end
    else
    begin
      state     <= next_state;
      ptr       <= next_ptr;
      window    <= next_window;
      pend_halt <= next_pend_halt;
      pend_shut <= next_pend_shut;
      from_host <= next_from_host;
      to_window <= next_to_window;
      io_ack    <= next_io_ack;
      io_rdata  <= next_io_rdata;
      pci_req   <= next_pci_req;
      pci_cmd   <= next_pci_cmd;
      pci_addr  <= next_pci_addr;
      pci_be    <= next_pci_be;
      pci_wdata <= next_pci_wdata;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic idle_req;
  assign idle_req = io_req && state == PCAT_IDLE;

  property p_ptr_load;
    idle_req && io_we && hit_ptr && full |=>
      ptr == ($past(io_wdata) & PCAT_PTR_MASK) && io_ack && !pci_req;
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded by full write");
  property p_partial;
    idle_req && hit_ptr && !full |=> $stable(ptr) && pci_req &&
      pci_addr[15:0] == $past(io_addr);
  endproperty
  a_partial: assert property (p_partial)
    else $error("narrow pointer access not forwarded");
  property p_plain_io;
    idle_req && hit_win && !ptr[PCAT_EN_BIT] |=>
      pci_req && (pci_cmd == PCAT_CMD_IO_RD || pci_cmd == PCAT_CMD_IO_WR);
  endproperty
  a_plain_io: assert property (p_plain_io)
    else $error("disabled window not sent as i/o");
  property p_cfg;
    idle_req && xlate && !(special && io_we) |=> pci_req &&
      pci_cmd == ($past(io_we) ? PCAT_CMD_CFG_WR : PCAT_CMD_CFG_RD) &&
      pci_be == $past(io_be);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("window access not a config cycle");

  property p_type0;
    idle_req && xlate && own_bus && !(special && io_we) |=>
      pci_addr[1:0] == PCAT_TT_TYPE0 && pci_addr[10:2] == ptr[10:2] &&
      $countones(pci_addr[31:11]) == ((dev >= PCAT_DEV_MIN &&
      dev <= PCAT_DEV_MAX) ? 1 : 0);
  endproperty
  a_type0: assert property (p_type0)
    else $error("bad type 0 address");

  property p_type1;
    idle_req && xlate && !own_bus |=>
      pci_addr == {ptr[31:2], PCAT_TT_TYPE1};
  endproperty
  a_type1: assert property (p_type1)
    else $error("bad type 1 address");

  property p_special;
    idle_req && xlate && special && io_we |=>
      pci_cmd == PCAT_CMD_SPECIAL && pci_wdata == $past(io_wdata);
  endproperty
  a_special: assert property (p_special)
    else $error("special pointer write not broadcast");

  property p_halt;
    state == PCAT_IDLE && !io_req && pend_halt |=> pci_req &&
      pci_cmd == PCAT_CMD_SPECIAL && pci_wdata[15:0] == PCAT_MSG_HALT;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt message not issued");

  property p_ptr_read;
    idle_req && !io_we && hit_ptr && full |=>
      io_ack && io_rdata == ptr && io_rdata[30:24] == 7'h0;
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer read wrong");
  property p_window;
    state == PCAT_BUS && pci_done && to_window && pci_be[0] &&
      pci_cmd == PCAT_CMD_CFG_RD |=> window[7:0] == $past(pci_rdata[7:0]);
  endproperty
  a_window: assert property (p_window)
    else $error("window lane not kept after config read");

  c_cfg_rd: cover property (pci_req && pci_cmd == PCAT_CMD_CFG_RD ##[1:8]
                            io_ack);
  c_spc: cover property (pci_req && pci_cmd == PCAT_CMD_SPECIAL);
  c_type1: cover property (pci_req && pci_addr[1:0] == PCAT_TT_TYPE1 &&
                           pci_cmd == PCAT_CMD_CFG_WR);
endmodule : pcat_translator
`default_nettype wire

// ===== verification/pcat_target_model.sv
// pci target stand-in that answers translated cycles after a set delay
`default_nettype none
module pcat_target_model
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pci_req,
  input  wire logic [31:0] pci_addr,
  input  wire logic [3:0]  delay,
  output var  logic        pci_done = 1'b0,
  output var  logic [31:0] pci_rdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // answer
  // ****
  int          cnt = -1;
  logic [31:0] held;
  // count down from a request and answer once with swapped address halves;
  // the data lines toggle whenever no answer is given
  always @(posedge clk)
  begin
    pci_done  <= 1'b0;
    pci_rdata <= ~pci_rdata;
    if (pci_req && !sys_rst)
    begin
      cnt  = delay;
      held = pci_addr;
    end
    if (cnt == 0)
    begin
      pci_done  <= 1'b1;
      pci_rdata <= {held[15:0], held[31:16]};
    end
    if (cnt >= 0)
      cnt = cnt - 1;
    if (sys_rst)
      cnt = -1;
  end
endmodule : pcat_target_model
`default_nettype wire

// ===== verification/pcat_translator_bench.sv
// self-checking bench for the configuration access translator
`default_nettype none
module pcat_translator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcat_pkg::*;
  // ****
  // stimulus and checking
  // ****
  logic        clk = 0, sys_rst = 1, io_req = 0, io_we = 0, io_ack;
  logic        halt_req = 0, shutdown_req = 0, pci_req, pci_done;
  logic [15:0] io_addr = 0;
  logic [3:0]  io_be = 0, pci_be, dly = 0;
  logic [31:0] io_wdata = 0, io_rdata, pci_addr, pci_wdata, pci_rdata;
  logic [31:0] rnd = 32'h2, ptr = 0;
  pcat_cmd_t   pci_cmd;
  logic [71:0] pq[$], e;
  logic [63:0] aq[$], a;
  int          miscompares = 0, compares = 0, cycles = 0;
  pcat_translator dut (.clk, .sys_rst, .io_req, .io_we, .io_addr, .io_be,
    .io_wdata, .io_ack, .io_rdata, .halt_req, .shutdown_req, .pci_req,
    .pci_cmd, .pci_addr, .pci_be, .pci_wdata, .pci_done, .pci_rdata);
  pcat_target_model partner (.clk, .sys_rst, .pci_req, .pci_addr,
    .delay(dly), .pci_done, .pci_rdata);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes
  // address phase value expected for an enabled pointer
  function automatic logic [31:0] cfg_addr(input logic [31:0] p);
    if (p[23:16] != 8'h00)
      return {p[31:2], 2'b01};
    return ((p[15:11] >= 5'h01 && p[15:11] <= 5'h15) ?
      32'h1 << (p[15:11] + 10) : 32'h0) | (p & 32'h7fc);
  endfunction : cfg_addr
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // one host access, then wait for its acknowledge
  task automatic io(input logic we, input logic [15:0] ad,
                    input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    io_req   <= 1'b1;
    io_we    <= we;
    io_addr  <= ad;
    io_be    <= be;
    io_wdata <= d;
    dly      <= rnd[3:0];
    rnd = lfsr(rnd);
    @(posedge clk);
    io_req <= 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      if (io_ack === 1'b1)
        break;
    end
  endtask : io
  task automatic fwd(input logic we, input logic [15:0] ad,
    input logic [3:0] be, input logic [31:0] d, input logic [3:0] c,
    input logic [31:0] pa);
    pq.push_back({c, be, pa, d});
    aq.push_back({we ? 32'h0 : lanes(be), pa[15:0], pa[31:16]});
    io(we, ad, be, d);
  endtask : fwd
  task automatic ptr_wr(input logic [31:0] p);
    aq.push_back(64'h0);
    io(1'b1, PCAT_PTR_OFS, 4'hf, p);
    ptr = p & 32'h80ff_ffff;
  endtask : ptr_wr
  task automatic ptr_rd;
    aq.push_back({32'hffff_ffff, ptr});
    io(1'b0, PCAT_PTR_OFS, 4'hf, 32'h0);
  endtask : ptr_rd
  task automatic win(input logic we, input logic [3:0] be,
                     input logic [31:0] d);
    logic [31:0] pa;
    logic [3:0]  c;
    pa = ptr[31] ? cfg_addr(ptr) : 32'h0cfc;
    c = ptr[31] ? (we ? PCAT_CMD_CFG_WR : PCAT_CMD_CFG_RD)
      : (we ? PCAT_CMD_IO_WR : PCAT_CMD_IO_RD);
    if (we && ptr[31:2] == PCAT_SPC_PTR[31:2])
    begin
      c  = PCAT_CMD_SPECIAL;
      pa = 32'h0;
    end
    fwd(we, PCAT_WIN_OFS, be, d, c, pa);
  endtask : win
  initial
  begin
    forever #2 clk = ~clk;
  end
  // compare every started pci cycle and every acknowledge with its note
  always @(negedge clk)
  begin
    if (pci_req === 1'b1 && pq.size() == 0)
      check(72'h1, 72'h0);
    else if (pci_req === 1'b1)
    begin
      e = pq.pop_front();
      check({pci_cmd, pci_be, pci_addr,
        pci_cmd[0] ? pci_wdata : e[31:0]}, e);
    end
    if (io_ack === 1'b1 && aq.size() == 0)
      check(72'h1, 72'h0);
    else if (io_ack === 1'b1)
    begin
      a = aq.pop_front();
      check({40'h0, io_rdata & a[63:32]}, {40'h0, a[31:0] & a[63:32]});
    end
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    ptr_rd();
    ptr_wr(32'hfeed_bee3);
    ptr_rd();
    fwd(1'b1, PCAT_PTR_OFS, 4'h1, 32'h5a, PCAT_CMD_IO_WR, 32'h0cf8);
    fwd(1'b0, PCAT_PTR_OFS, 4'h3, 32'h0, PCAT_CMD_IO_RD, 32'h0cf8);
    ptr_rd();
    fwd(1'b0, 16'h0cf4, 4'hf, 32'h0, PCAT_CMD_IO_RD, 32'h0cf4);
    ptr_wr(32'h0000_0104);
    win(1'b0, 4'hf, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      ptr_wr({8'h80, 8'h00, i[4:0], rnd[10:0]});
      win(i[0], rnd[7:4] | 4'h1, rnd);
    end
    repeat (3)
    begin
      ptr_wr({8'h80, rnd[23:16] | 8'h01, rnd[15:0]});
      win(1'b1, 4'hf, rnd);
      win(1'b0, 4'hc, 32'h0);
    end
    ptr_wr(PCAT_SPC_PTR);
    win(1'b1, 4'hf, rnd);
    win(1'b0, 4'hf, 32'h0);
    pq.push_back({PCAT_CMD_SPECIAL, PCAT_BE_FULL, 32'h0, 32'h1});
    pq.push_back({PCAT_CMD_SPECIAL, PCAT_BE_FULL, 32'h0, 32'h0});
    @(posedge clk);
    halt_req     <= 1'b1;
    shutdown_req <= 1'b1;
    @(posedge clk);
    halt_req     <= 1'b0;
    shutdown_req <= 1'b0;
    repeat (80)
    begin
      @(negedge clk);
      if (pq.size() == 0)
        break;
    end
    check(pq.size() + aq.size(), 72'h0);
    test_done();
  end
endmodule : pcat_translator_bench
`default_nettype wire
